//--- shared/opcode_timing_pkg.sv
// Opcode classes, lengths and cycle counts for the instruction decoder
// Assumes a single system clock; counts are in system clock cycles
package opcode_timing_pkg;

   localparam logic [3:0] CYCLES_TWO   = 4'h2;
   localparam logic [3:0] CYCLES_FOUR  = 4'h4;
   localparam logic [3:0] CYCLES_SIX   = 4'h6;
   localparam logic [3:0] CYCLES_EIGHT = 4'h8;

   localparam logic [1:0] BYTES_ONE    = 2'h1;
   localparam logic [1:0] BYTES_TWO    = 2'h2;
   localparam logic [1:0] BYTES_THREE  = 2'h3;

   localparam int unsigned REG_SEL_MSB = 2;
   localparam int unsigned PAGE_LSB    = 5;

   localparam logic [3:0] COUNT_RESET  = 4'h0;

   typedef enum logic [5:0] {
      OP_UNKNOWN, OP_NOP, OP_SWAP, OP_RL, OP_RLC, OP_RR, OP_RRC,
      OP_MOV_A_REG, OP_MOV_A_DIR, OP_MOV_A_IND, OP_MOV_A_IMM,
      OP_MOV_REG_A, OP_MOV_REG_DIR, OP_MOV_REG_IMM, OP_MOV_DIR_A,
      OP_MOV_DIR_REG, OP_MOV_DIR_DIR, OP_MOV_DIR_IND, OP_MOV_DIR_IMM,
      OP_MOV_IND_A, OP_MOV_IND_DIR, OP_MOV_IND_IMM, OP_LOAD_POINTER,
      OP_CODE_READ_DP, OP_CODE_READ_PC, OP_XREAD_SHORT, OP_XREAD_LONG,
      OP_XWRITE_SHORT, OP_XWRITE_LONG, OP_PUSH, OP_POP, OP_XCH_REG,
      OP_XCH_DIR, OP_XCH_IND, OP_XCH_NIBBLE, OP_CARRY_BIT,
      OP_BIT_LOGIC, OP_BIT_TO_CARRY, OP_CARRY_TO_BIT, OP_BIT_CLR,
      OP_BIT_SET, OP_BIT_CPL, OP_ACALL, OP_LCALL, OP_RET, OP_RETI,
      OP_AJMP, OP_LJMP, OP_SJMP, OP_COND_BRANCH, OP_BIT_BRANCH,
      OP_BIT_BRANCH_CLR, OP_JMP_IND, OP_CMP_BRANCH, OP_DEC_BRANCH
   } op_class_t;

endpackage : opcode_timing_pkg

//--- rtl/cpu_opcode_timing_decoder.sv
// Instruction decoder: class, length, cycle count and operand fields
// Opcode comes from fetch logic on the same clock; branch outcome too
// Unlisted codes decode as unknown: one byte, two cycles
//
// Function
// - Swap C4, rotate left 23, rotate left carry 33: two cycles.
// - Rotate right 03, through carry 13: two cycles, carry joins rotation.
// - Register from direct A8-AF: two bytes, four cycles; E8-EF two cycles.
// - Direct to direct move 85: three bytes, four cycles.
// - Code table reads 93 and 83 take eight cycles.
// - Short external read E2-E3, write F2-F3: eight cycles.
// - Long external read E0, write F0: one byte, eight cycles.
// - Push C0 and pop D0: two bytes, four cycles.
// - D6-D7 swap low nibble only; C8-CF, C5, C6-C7 full byte.
// - Load data pointer 90: three bytes, four cycles.
// - Carry logic 82, B0, 72, A0: two bytes, four cycles.
// - Carry to bit 92 four cycles; bit to carry A2 two.
// - Bit clear C2, set D2, complement B2: two bytes, two cycles.
// - Calls six cycles: absolute x1 two bytes, long 12 three.
// - Returns 22 and 32: one byte, six cycles.
// - Jumps six cycles: 80 two, absolute x1 two, 02 three bytes.
// - Bit branches four or six cycles; 10 also clears bit.
// - Compare branches B5, B4, B8-BF: three bytes, four or six.
// - Decrement branch D8-DF two bytes, D5 three: four or six.
// - Indirect jump 73: one byte, six cycles.
// - Eight-code blocks pick register from low three opcode bits.
// - Absolute jump/call page is top three opcode bits.
// - Cycles counted in system clocks; lengths one to three bytes.
`timescale 1ns/100ps
`default_nettype none

module cpu_opcode_timing_decoder
   import opcode_timing_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic                  reset,
   input  wire logic                  opcode_valid,
   input  wire logic [7:0]            opcode,
   input  wire logic                  branch_taken,
   output logic                       busy,
   output logic                       done,
   output var opcode_timing_pkg::op_class_t op_class,
   output logic [1:0]                 byte_count,
   output logic [3:0]                 cycle_count,
   output logic [2:0]                 working_register,
   output logic                       indirect_register,
   output logic [2:0]                 page_bits,
   output logic                       carry_in_rotate,
   output logic                       nibble_only,
   output logic                       clear_tested_bit,
   output logic                       pc_only
);
   import opcode_timing_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Combinational decode
   op_class_t  cls_next;
   logic [1:0] len_next;
   logic [3:0] cyc_next;
   logic       cond_next;

   always_comb begin
      cls_next  = OP_UNKNOWN;
      len_next  = BYTES_ONE;
      cyc_next  = CYCLES_TWO;
      cond_next = 1'b0;
      if (opcode[3:0] == 4'h1) begin
         len_next = BYTES_TWO;
         cyc_next = CYCLES_SIX;
         cls_next = opcode[4] ? OP_ACALL : OP_AJMP;
      end else if (opcode[7:3] == 5'h1D) begin
         cls_next = OP_MOV_A_REG;
      end else if (opcode[7:3] == 5'h15) begin
         cls_next = OP_MOV_REG_DIR;
         len_next = BYTES_TWO;
         cyc_next = CYCLES_FOUR;
      end else if (opcode[7:3] == 5'h1F) begin
         cls_next = OP_MOV_REG_A;
      end else if (opcode[7:3] == 5'h0F) begin
         cls_next = OP_MOV_REG_IMM;
         len_next = BYTES_TWO;
      end else if (opcode[7:3] == 5'h11) begin
         cls_next = OP_MOV_DIR_REG;
         len_next = BYTES_TWO;
         cyc_next = CYCLES_FOUR;
      end else if (opcode[7:3] == 5'h19) begin
         cls_next = OP_XCH_REG;
      end else if (opcode[7:3] == 5'h17) begin
         cls_next  = OP_CMP_BRANCH;
         len_next  = BYTES_THREE;
         cond_next = 1'b1;
      end else if (opcode[7:3] == 5'h1B) begin
         cls_next  = OP_DEC_BRANCH;
         len_next  = BYTES_TWO;
         cond_next = 1'b1;
      end else begin
         case (opcode)
            8'h00: cls_next = OP_NOP;
            8'hC4: cls_next = OP_SWAP;
            8'h23: cls_next = OP_RL;
            8'h33: cls_next = OP_RLC;
            8'h03: cls_next = OP_RR;
            8'h13: cls_next = OP_RRC;
            8'hE5: begin
               cls_next = OP_MOV_A_DIR;
               len_next = BYTES_TWO;
            end
            8'hE6, 8'hE7: cls_next = OP_MOV_A_IND;
            8'h74: begin
               cls_next = OP_MOV_A_IMM;
               len_next = BYTES_TWO;
            end
            8'hF5: begin
               cls_next = OP_MOV_DIR_A;
               len_next = BYTES_TWO;
            end
            8'h85: begin
               cls_next = OP_MOV_DIR_DIR;
               len_next = BYTES_THREE;
               cyc_next = CYCLES_FOUR;
            end
            8'h86, 8'h87: begin
               cls_next = OP_MOV_DIR_IND;
               len_next = BYTES_TWO;
               cyc_next = CYCLES_FOUR;
            end
            8'h75: begin
               cls_next = OP_MOV_DIR_IMM;
               len_next = BYTES_THREE;
               cyc_next = CYCLES_FOUR;
            end
            8'hF6, 8'hF7: cls_next = OP_MOV_IND_A;
            8'hA6, 8'hA7: begin
               cls_next = OP_MOV_IND_DIR;
               len_next = BYTES_TWO;
               cyc_next = CYCLES_FOUR;
            end
            8'h76, 8'h77: begin
               cls_next = OP_MOV_IND_IMM;
               len_next = BYTES_TWO;
            end
            8'h90: begin
               cls_next = OP_LOAD_POINTER;
               len_next = BYTES_THREE;
               cyc_next = CYCLES_FOUR;
            end
            8'h93: begin
               cls_next = OP_CODE_READ_DP;
               cyc_next = CYCLES_EIGHT;
            end
            8'h83: begin
               cls_next = OP_CODE_READ_PC;
               cyc_next = CYCLES_EIGHT;
            end
            8'hE2, 8'hE3: begin
               cls_next = OP_XREAD_SHORT;
               cyc_next = CYCLES_EIGHT;
            end
            8'hF2, 8'hF3: begin
               cls_next = OP_XWRITE_SHORT;
               cyc_next = CYCLES_EIGHT;
            end
            8'hE0: begin
               cls_next = OP_XREAD_LONG;
               cyc_next = CYCLES_EIGHT;
            end
            8'hF0: begin
               cls_next = OP_XWRITE_LONG;
               cyc_next = CYCLES_EIGHT;
            end
            8'hC0, 8'hD0: begin
               cls_next = opcode[4] ? OP_POP : OP_PUSH;
               len_next = BYTES_TWO;
               cyc_next = CYCLES_FOUR;
            end
            8'hC5: begin
               cls_next = OP_XCH_DIR;
               len_next = BYTES_TWO;
            end
            8'hC6, 8'hC7: cls_next = OP_XCH_IND;
            8'hD6, 8'hD7: cls_next = OP_XCH_NIBBLE;
            8'hC3, 8'hD3, 8'hB3: cls_next = OP_CARRY_BIT;
            8'h82, 8'hB0, 8'h72, 8'hA0: begin
               cls_next = OP_BIT_LOGIC;
               len_next = BYTES_TWO;
               cyc_next = CYCLES_FOUR;
            end
            8'hA2: begin
               cls_next = OP_BIT_TO_CARRY;
               len_next = BYTES_TWO;
            end
            8'h92: begin
               cls_next = OP_CARRY_TO_BIT;
               len_next = BYTES_TWO;
               cyc_next = CYCLES_FOUR;
            end
            8'hC2, 8'hD2, 8'hB2: begin
               len_next = BYTES_TWO;
               cls_next = (opcode == 8'hC2) ? OP_BIT_CLR :
                          (opcode == 8'hD2) ? OP_BIT_SET : OP_BIT_CPL;
            end
            8'h12, 8'h02: begin
               cls_next = opcode[4] ? OP_LCALL : OP_LJMP;
               len_next = BYTES_THREE;
               cyc_next = CYCLES_SIX;
            end
            8'h22, 8'h32: begin
               cls_next = opcode[4] ? OP_RETI : OP_RET;
               cyc_next = CYCLES_SIX;
            end
            8'h80: begin
               cls_next = OP_SJMP;
               len_next = BYTES_TWO;
               cyc_next = CYCLES_SIX;
            end
            8'h73: begin
               cls_next = OP_JMP_IND;
               cyc_next = CYCLES_SIX;
            end
            8'h40, 8'h50, 8'h60, 8'h70: begin
               cls_next  = OP_COND_BRANCH;
               len_next  = BYTES_TWO;
               cond_next = 1'b1;
            end
            8'h20, 8'h30, 8'h10: begin
               cls_next  = (opcode == 8'h10) ? OP_BIT_BRANCH_CLR
                                             : OP_BIT_BRANCH;
               len_next  = BYTES_THREE;
               cond_next = 1'b1;
            end
            8'hB5, 8'hB4, 8'hB6, 8'hB7: begin
               cls_next  = OP_CMP_BRANCH;
               len_next  = BYTES_THREE;
               cond_next = 1'b1;
            end
            8'hD5: begin
               cls_next  = OP_DEC_BRANCH;
               len_next  = BYTES_THREE;
               cond_next = 1'b1;
            end
            default: cls_next = OP_UNKNOWN;
         endcase
      end
      if (cond_next) begin
         cyc_next = branch_taken ? CYCLES_SIX : CYCLES_FOUR;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Cycle counter in system clocks
   // Offers while busy are ignored; next take once count is zero
   logic [3:0] remain_reg;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         remain_reg <= COUNT_RESET;
      end else if (opcode_valid && remain_reg == COUNT_RESET) begin
         remain_reg <= cyc_next - 4'h1;
      end else if (remain_reg != COUNT_RESET) begin
         remain_reg <= remain_reg - 4'h1;
      end
   end

   assign busy = (remain_reg != COUNT_RESET);
   assign done = (remain_reg == 4'h1);

   ////////////////////////////////////////////////////////////////////////
   // Latched decode results
   // Fields hold until the next taken opcode
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         op_class          <= OP_NOP;
         byte_count        <= BYTES_ONE;
         cycle_count       <= COUNT_RESET;
         working_register  <= 3'h0;
         indirect_register <= 1'b0;
         page_bits         <= 3'h0;
         carry_in_rotate   <= 1'b0;
         nibble_only       <= 1'b0;
         clear_tested_bit  <= 1'b0;
         pc_only           <= 1'b0;
      end else if (opcode_valid && remain_reg == COUNT_RESET) begin
         op_class          <= cls_next;
         byte_count        <= len_next;
         cycle_count       <= cyc_next;
         working_register  <= opcode[REG_SEL_MSB:0];
         indirect_register <= opcode[0];
         page_bits         <= opcode[7:PAGE_LSB];
         carry_in_rotate   <= (cls_next == OP_RLC) ||
                              (cls_next == OP_RRC);
         nibble_only       <= (cls_next == OP_XCH_NIBBLE);
         clear_tested_bit  <= (cls_next == OP_BIT_BRANCH_CLR);
         pc_only           <= (cls_next == OP_NOP);
      end
   end

endmodule : cpu_opcode_timing_decoder

`default_nettype wire

//--- testbench/op_dec_chk_asserts.sv
// Port checker for the opcode timing decoder
// Bound to every decoder instance; single clock domain
`timescale 1ns/100ps
`default_nettype none
module op_dec_chk (
   input wire logic clock, reset, opcode_valid, branch_taken, busy, done,
   input wire logic [7:0] opcode,
   input var opcode_timing_pkg::op_class_t op_class,
   input wire logic [1:0] byte_count,
   input wire logic [3:0] cycle_count,
   input wire logic [2:0] working_register, page_bits,
   input wire logic indirect_register, carry_in_rotate, nibble_only,
   input wire logic clear_tested_bit, pc_only
);
   import opcode_timing_pkg::*;
   logic take;
   assign take = opcode_valid && !busy;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////
   AST_SWAP: assert property (take && opcode == 8'hC4 |=>
      op_class == OP_SWAP && busy && done ##1 !busy)
      else $error("swap timing wrong");
   AST_ROTATE_CARRY: assert property (take && opcode == 8'h13 |=>
      carry_in_rotate && cycle_count == 4'h2) else $error("rotate carry");
   AST_DIR_MOVE: assert property (take && opcode == 8'h85 |=>
      (busy && byte_count == 2'h3 && cycle_count == 4'h4)[*3] ##1 !busy)
      else $error("direct move timing wrong");
   AST_EXT_SHORT: assert property (take && opcode[7:1] == 7'h71 |=>
      indirect_register == $past(opcode[0]) && cycle_count == 4'h8)
      else $error("short external access wrong");
   AST_EXT_LONG: assert property (take && opcode[7:4] >= 4'hE &&
      opcode[3:0] == 4'h0 |=> busy[*7] ##1 !busy && byte_count == 2'h1)
      else $error("long external access wrong");
   AST_REG_SELECT: assert property (take && opcode[7:3] == 5'h1D |=>
      working_register == $past(opcode[2:0]) && op_class == OP_MOV_A_REG)
      else $error("register select wrong");
   AST_PAGE: assert property (take && opcode[4:0] == 5'h01 |=>
      page_bits == $past(opcode[7:5]) && op_class == OP_AJMP &&
      cycle_count == 4'h6) else $error("absolute page wrong");
   AST_BRANCH: assert property (take && opcode == 8'hB5 |=>
      cycle_count == ($past(branch_taken) ? 4'h6 : 4'h4))
      else $error("branch cycles wrong");
   AST_NIBBLE: assert property (take && opcode[7:1] == 7'h6B |=>
      nibble_only && op_class == OP_XCH_NIBBLE) else $error("nibble xch");
   AST_BIT_CLEAR: assert property (take && opcode == 8'h10 |=>
      clear_tested_bit && byte_count == 2'h3) else $error("bit clear");
   AST_NOP: assert property (take && opcode == 8'h00 |=>
      pc_only && cycle_count == 4'h2) else $error("nop wrong");
   AST_DONE_LAST: assert property (done |-> busy ##1 !busy)
      else $error("done not in last cycle");
   AST_HOLD: assert property (busy && !done |=> $stable(op_class))
      else $error("decode changed while busy");
endmodule : op_dec_chk
bind cpu_opcode_timing_decoder op_dec_chk chk (.clock, .reset, .opcode_valid,
   .branch_taken, .busy, .done, .opcode, .op_class, .byte_count, .cycle_count,
   .working_register, .page_bits, .indirect_register, .carry_in_rotate,
   .nibble_only, .clear_tested_bit, .pc_only);
`default_nettype wire

//--- testbench/program_memory_model.sv
// Program memory holding the opcode stream for the bench
// Combinational read, addressed by the bench
`timescale 1ns/100ps
`default_nettype none
module program_memory_model (
   input  wire logic [5:0] addr,
   output logic      [7:0] code
);
   logic [7:0] rom [60] = '{8'hC4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hA8,
      8'hE8, 8'h85, 8'h93, 8'h83, 8'hE2, 8'hF2, 8'hE0, 8'hF0, 8'hC0, 8'hD0,
      8'hD6, 8'hC8, 8'hC5, 8'hC6, 8'h90, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'h92,
      8'hA2, 8'hC2, 8'hD2, 8'hB2, 8'h11, 8'h12, 8'h22, 8'h32, 8'h80, 8'h01,
      8'h02, 8'h10, 8'hB5, 8'hB4, 8'hB8, 8'hD8, 8'hD5, 8'h73, 8'h00, 8'h40,
      8'h50, 8'h60, 8'h70, 8'h20, 8'h30, 8'hB6, 8'hC3, 8'hE5, 8'h74, 8'hF8,
      8'h88, 8'h75, 8'hA6, 8'hA4};
   // Out of range reads a changing pattern
   assign code = (addr < 6'h3C) ? rom[addr] : {addr, addr[1:0]};
endmodule : program_memory_model
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the opcode timing decoder
// Opcodes come from the program memory model; checker is bound
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import opcode_timing_pkg::*;
   typedef struct {op_class_t c; logic [3:0] n; logic [1:0] b;
      logic [7:0] op;} note_t;
   logic clock, reset, opcode_valid, branch_taken, busy, done;
   logic [7:0] opcode, rom_code;
   logic [5:0] rom_addr;
   op_class_t op_class;
   logic [1:0] byte_count;
   logic [3:0] cycle_count;
   logic [2:0] working_register, page_bits;
   logic indirect_register, carry_in_rotate, nibble_only;
   logic clear_tested_bit, pc_only;
   int err_count = 0;
   int check_count = 0;
   int run = 0;
   note_t notes[$];
   note_t cur;
   logic [31:0] rnd = 32'h2CCA;
   logic prev_busy = 1'b0;
   op_class_t cls [60] = '{OP_SWAP, OP_RL, OP_RLC, OP_RR, OP_RRC,
      OP_MOV_REG_DIR, OP_MOV_A_REG, OP_MOV_DIR_DIR, OP_CODE_READ_DP,
      OP_CODE_READ_PC, OP_XREAD_SHORT, OP_XWRITE_SHORT, OP_XREAD_LONG,
      OP_XWRITE_LONG, OP_PUSH, OP_POP, OP_XCH_NIBBLE, OP_XCH_REG, OP_XCH_DIR,
      OP_XCH_IND, OP_LOAD_POINTER, OP_BIT_LOGIC, OP_BIT_LOGIC, OP_BIT_LOGIC,
      OP_BIT_LOGIC, OP_CARRY_TO_BIT, OP_BIT_TO_CARRY, OP_BIT_CLR, OP_BIT_SET,
      OP_BIT_CPL, OP_ACALL, OP_LCALL, OP_RET, OP_RETI, OP_SJMP, OP_AJMP,
      OP_LJMP, OP_BIT_BRANCH_CLR, OP_CMP_BRANCH, OP_CMP_BRANCH, OP_CMP_BRANCH,
      OP_DEC_BRANCH, OP_DEC_BRANCH, OP_JMP_IND, OP_NOP, OP_COND_BRANCH,
      OP_COND_BRANCH, OP_COND_BRANCH, OP_COND_BRANCH, OP_BIT_BRANCH,
      OP_BIT_BRANCH, OP_CMP_BRANCH, OP_CARRY_BIT, OP_MOV_A_DIR, OP_MOV_A_IMM,
      OP_MOV_REG_A, OP_MOV_DIR_REG, OP_MOV_DIR_IMM, OP_MOV_IND_DIR,
      OP_UNKNOWN};
   // Bytes in high digit, cycles in low digit, zero for conditional
   logic [7:0] bc [60] = '{8'h12, 8'h12, 8'h12, 8'h12, 8'h12, 8'h24,
      8'h12, 8'h34, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h24, 8'h24,
      8'h12, 8'h12, 8'h22, 8'h12, 8'h34, 8'h24, 8'h24, 8'h24, 8'h24, 8'h24,
      8'h22, 8'h22, 8'h22, 8'h22, 8'h26, 8'h36, 8'h16, 8'h16, 8'h26, 8'h26,
      8'h36, 8'h30, 8'h30, 8'h30, 8'h30, 8'h20, 8'h30, 8'h16, 8'h12, 8'h20,
      8'h20, 8'h20, 8'h20, 8'h30, 8'h30, 8'h30, 8'h12, 8'h22, 8'h22, 8'h12,
      8'h24, 8'h34, 8'h24, 8'h12};
   ////////////////////////////////////////////////////////////////////////
   cpu_opcode_timing_decoder dut (.clock, .reset, .opcode_valid, .opcode,
      .branch_taken, .busy, .done, .op_class, .byte_count, .cycle_count,
      .working_register, .indirect_register, .page_bits, .carry_in_rotate,
      .nibble_only, .clear_tested_bit, .pc_only);
   program_memory_model mem (.addr(rom_addr), .code(rom_code));
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [7:0] msk(input int i);
      case (i)
         5, 6, 17, 40, 41, 55, 56: return 8'h07;
         10, 11, 16, 19, 51: return 8'h01;
         30, 35: return 8'hE0;
         default: return 8'h00;
      endcase
   endfunction : msk
   task automatic check(input string nm, input logic [7:0] exp, got);
      check_count++;
      if (exp !== got) begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         err_count++;
      end
   endtask : check
   task automatic results;
      $display("Checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   // Offer one opcode, held through busy until taken
   task automatic issue(input int i);
      logic b;
      int k;
      rom_addr = 6'(i);
      #1;
      rnd = lfsr(rnd);
      opcode = rom_code | (rnd[7:0] & msk(i));
      branch_taken = rnd[8];
      opcode_valid = 1'b1;
      notes.push_back('{cls[i], (bc[i][3:0] != 4'h0) ? bc[i][3:0] :
         (rnd[8] ? 4'h6 : 4'h4), bc[i][5:4], opcode});
      for (k = 0; k < 20; k++) begin
         b = busy;
         @(posedge clock);
         if (!b) break;
         @(negedge clock);
      end
      if (k == 20) begin
         $display("Error take expected within 20 cycles seen busy");
         err_count++;
         results();
      end
      @(negedge clock);
   endtask : issue
   // Result monitor
   always @(negedge clock) begin
      if (!reset && busy && !prev_busy) begin
         if (notes.size() == 0) begin
            $display("Error queue expected note seen none");
            err_count++;
         end else cur = notes.pop_front();
         check("class", 8'(cur.c), 8'(op_class));
         check("bytes", 8'(cur.b), 8'(byte_count));
         check("cycles", 8'(cur.n), 8'(cycle_count));
         check("reg", 8'(cur.op[2:0]), 8'(working_register));
         check("ind", 8'(cur.op[0]), 8'(indirect_register));
         check("page", 8'(cur.op[7:5]), 8'(page_bits));
         check("flags", 8'({cur.op == 8'h33 || cur.op == 8'h13,
            cur.op[7:1] == 7'h6B, cur.op == 8'h10, cur.op == 8'h00}),
            8'({carry_in_rotate, nibble_only, clear_tested_bit,
            pc_only}));
         run = 1;
      end else if (busy) run++;
      else if (prev_busy) check("length", 8'(cur.n), 8'(run + 1));
      if (busy && done) check("done", 8'(cur.n), 8'(run + 1));
      prev_busy <= busy;
   end
   initial begin
      reset = 1'b1;
      opcode_valid = 1'b0;
      opcode = 8'h00;
      branch_taken = 1'b0;
      rom_addr = 6'h00;
      repeat (5) @(posedge clock);
      @(negedge clock);
      check("reset", 8'h10, {busy, done, byte_count, cycle_count});
      check("reset class", 8'(OP_NOP), 8'(op_class));
      reset = 1'b0;
      repeat (2) for (int i = 0; i < 60; i++) issue(i);
      opcode_valid = 1'b0;
      repeat (10) @(negedge clock);
      check("pending", 8'h00, 8'(notes.size()));
      results();
   end
endmodule : tb_top
`default_nettype wire
